// ### ptu_map.svh
// register map, field positions, divisors and timing constants of the timer unit
`ifndef PTU_MAP_SVH
`define PTU_MAP_SVH

`define PTU_IDX_CTL_A      6'h0C
`define PTU_IDX_CTL_B      6'h0D
`define PTU_IDX_CTL_CD     6'h0E
`define PTU_IDX_DATA_A     6'h0F
`define PTU_IDX_DATA_B     6'h10
`define PTU_IDX_DATA_C     6'h11
`define PTU_IDX_DATA_D     6'h12
`define PTU_IDX_EDGE       6'h13

`define PTU_CTL_RST_BIT    4
`define PTU_EDGE_BIT_A     4
`define PTU_EDGE_BIT_B     3

`define PTU_MODE_STOP      4'h0
`define PTU_MODE_EVENT     4'h8
`define PTU_CNT_RELOAD     8'h01

`define PTU_DIV_4          8'h04
`define PTU_DIV_10         8'h0A
`define PTU_DIV_16         8'h10
`define PTU_DIV_50         8'h32
`define PTU_DIV_64         8'h40
`define PTU_DIV_100        8'h64
`define PTU_DIV_200        8'hC8

`define PTU_PCLK_NS        20
`define PTU_TCLK_NS        400
`define PTU_TICK_DIV       8'((`PTU_TCLK_NS + `PTU_PCLK_NS - 1) / `PTU_PCLK_NS)

`endif

// ### ptu_pkg.sv
// types of the prescaled down timer unit
package ptu_pkg;

   typedef struct packed {
      logic [3:0]      ctl_a;
      logic [3:0]      ctl_b;
      logic [2:0]      ctl_c;
      logic [2:0]      ctl_d;
      logic [7:0]      edge_sel;
      logic [7:0]      tick_div;
      logic [3:0][7:0] psc;
      logic [3:0][7:0] cnt;
      logic [3:0][7:0] tconst;
      logic [3:0][7:0] hold;
      logic [3:0]      tout;
      logic [3:0]      tmo;
      logic [1:0][2:0] aux_sync;
      logic [1:0]      aux_st;
      logic [1:0]      aux_prev;
      logic [1:0]      chan_prev;
      logic [1:0]      chan_evt;
   } ptu_state_t;

endpackage

// ### ptu_timer_unit.sv
// four prescaled 8-bit down timers behind an apb slave
//
// What this block does
// - control field picks stop, delay, event, pulse modes
// - stopped timer holds count, clears prescaler
// - delay mode prescaler emits periodic count pulses, on A and B only at active aux level
// - count pulse decrements; at 01 reload, time-out
// - time-out pulses drive timer interrupt channel
// - each time-out toggles timer output pin
// - main counter 8-bit down, readable anytime
// - read returns count held before access phase
// - data write sets constant, loads if stopped
// - running write loads at next pass through 01
// - constant 01 every pulse, 00 every 256
// - prescale change: first time-out may be off
// - only A and B use auxiliary inputs
// - pulse width: inactive aux input halts timer
// - edge bits set aux active level
// - channels 4 and 3 serve aux inputs
// - pulse width mode inverts channel edge
// - event mode: aux edge is count pulse
// - output reset bit forces A and B outputs low on write
// - reset lowers outputs, keeps counters and constants
`include "ptu_map.svh"
`timescale 1ns/100ps
`default_nettype none

module ptu_timer_unit (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        timer_a_aux_input,
   input  wire logic        timer_b_aux_input,
   output logic             timer_a_out,
   output logic             timer_b_out,
   output logic             timer_c_out,
   output logic             timer_d_out,
   output logic             timer_a_timeout,
   output logic             timer_b_timeout,
   output logic             timer_c_timeout,
   output logic             timer_d_timeout,
   output logic             gp_interrupt_channel_4,
   output logic             gp_interrupt_channel_3
);

   ptu_pkg::ptu_state_t s_r;
   ptu_pkg::ptu_state_t s_nxt;

   logic [5:0] idx;
   logic       addr_ok;
   logic       mapped;
   logic       access;
   logic       wr;
   logic       tick;

   assign idx     = paddr[7:2];
   assign addr_ok = (paddr[1:0] == 2'b00);
   assign access  = psel & penable;
   assign wr      = access & pwrite & addr_ok;
   assign mapped  = addr_ok && idx >= `PTU_IDX_CTL_A && idx <= `PTU_IDX_EDGE;
   assign tick    = (s_r.tick_div == 8'(`PTU_TICK_DIV - 8'h01));

   // prescale code to division ratio
   function automatic logic [7:0] ptu_div(input logic [2:0] code);
      logic [7:0] d;
      d = `PTU_DIV_4;
      unique case (code)
         3'h1: d = `PTU_DIV_4;
         3'h2: d = `PTU_DIV_10;
         3'h3: d = `PTU_DIV_16;
         3'h4: d = `PTU_DIV_50;
         3'h5: d = `PTU_DIV_64;
         3'h6: d = `PTU_DIV_100;
         3'h7: d = `PTU_DIV_200;
         3'h0: d = `PTU_DIV_4;
      endcase
      return d;
   endfunction

   always_comb begin
      logic [3:0] mode;
      logic       stopped;
      logic       ev_mode;
      logic       pw_mode;
      logic       gate;
      logic       aux_edge;
      logic       cpulse;
      logic       act;
      logic       chan;
      logic [7:0] div;
      logic       dwr;
      logic       rst_out;
      mode     = `PTU_MODE_STOP;
      stopped  = 1'b1;
      ev_mode  = 1'b0;
      pw_mode  = 1'b0;
      gate     = 1'b0;
      aux_edge = 1'b0;
      cpulse   = 1'b0;
      act      = 1'b0;
      chan     = 1'b0;
      div      = `PTU_DIV_4;
      dwr      = 1'b0;
      rst_out  = 1'b0;
      s_nxt    = s_r;
      s_nxt.tmo      = 4'h0;
      s_nxt.chan_evt = 2'b00;
      s_nxt.tick_div = tick ? 8'h00 : 8'(s_r.tick_div + 8'h01);

      // three-stage sync; stable value moves only when stages 2 and 3 agree
      for (int a = 0; a < 2; a++) begin
         s_nxt.aux_sync[a] = {s_r.aux_sync[a][1:0], (a == 0) ? timer_a_aux_input : timer_b_aux_input};
         if (s_r.aux_sync[a][1] == s_r.aux_sync[a][2]) begin
            s_nxt.aux_st[a] = s_r.aux_sync[a][2];
         end
         s_nxt.aux_prev[a] = s_r.aux_st[a];
      end

      if (wr) begin
         unique case (idx)
            `PTU_IDX_CTL_A:  s_nxt.ctl_a = pwdata[3:0];
            `PTU_IDX_CTL_B:  s_nxt.ctl_b = pwdata[3:0];
            `PTU_IDX_CTL_CD: begin
               s_nxt.ctl_c = pwdata[6:4];
               s_nxt.ctl_d = pwdata[2:0];
            end
            `PTU_IDX_EDGE:   s_nxt.edge_sel = pwdata[7:0];
            default: ;
         endcase
      end

      for (int t = 0; t < 4; t++) begin
         unique case (t)
            0: mode = s_r.ctl_a;
            1: mode = s_r.ctl_b;
            2: mode = {1'b0, s_r.ctl_c};
            default: mode = {1'b0, s_r.ctl_d};
         endcase
         stopped = (mode == `PTU_MODE_STOP);
         ev_mode = (mode == `PTU_MODE_EVENT) && (t < 2);
         pw_mode = mode[3] && !ev_mode && (t < 2);
         div     = ptu_div(mode[2:0]);
         act     = 1'b0;
         gate    = 1'b1;
         aux_edge = 1'b0;
         if (t < 2) begin
            act = (t == 0) ? s_r.edge_sel[`PTU_EDGE_BIT_A] : s_r.edge_sel[`PTU_EDGE_BIT_B];
            gate = (s_r.aux_st[t] == act);
            aux_edge = (s_r.aux_st[t] != s_r.aux_prev[t]) && (s_r.aux_st[t] == act);
            chan = s_r.aux_st[t] ^ pw_mode;
            s_nxt.chan_prev[t] = chan;
            s_nxt.chan_evt[t]  = (chan != s_r.chan_prev[t]) && (chan == act);
         end

         cpulse = 1'b0;
         if (stopped || ev_mode) begin
            s_nxt.psc[t] = 8'h00;
         end else if (tick && gate) begin
            if (s_r.psc[t] >= 8'(div - 8'h01)) begin
               s_nxt.psc[t] = 8'h00;
               cpulse = 1'b1;
            end else begin
               s_nxt.psc[t] = 8'(s_r.psc[t] + 8'h01);
            end
         end
         if (ev_mode) begin
            cpulse = aux_edge;
         end

         if (cpulse) begin
            if (s_r.cnt[t] == `PTU_CNT_RELOAD) begin
               s_nxt.cnt[t]  = s_r.tconst[t];
               s_nxt.tmo[t]  = 1'b1;
               s_nxt.tout[t] = ~s_r.tout[t];
            end else begin
               s_nxt.cnt[t] = 8'(s_r.cnt[t] - 8'h01);
            end
         end

         dwr = wr && (idx == 6'(`PTU_IDX_DATA_A + 6'(t)));
         if (dwr) begin
            s_nxt.tconst[t] = pwdata[7:0];
            if (stopped) begin
               s_nxt.cnt[t] = pwdata[7:0];
            end
         end

         rst_out = wr && pwdata[`PTU_CTL_RST_BIT] && (t < 2) &&
                   (idx == 6'(`PTU_IDX_CTL_A + 6'(t)));
         if (rst_out) begin
            s_nxt.tout[t] = 1'b0;
         end

         // hold frozen through the access phase so the read is coherent
         if (!access) begin
            s_nxt.hold[t] = s_r.cnt[t];
         end
      end
   end

   // counters and constants keep their value through reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.ctl_a     <= 4'h0;
         s_r.ctl_b     <= 4'h0;
         s_r.ctl_c     <= 3'h0;
         s_r.ctl_d     <= 3'h0;
         s_r.edge_sel  <= 8'h00;
         s_r.tick_div  <= 8'h00;
         s_r.psc       <= 32'h0000_0000;
         s_r.hold      <= 32'h0000_0000;
         s_r.tout      <= 4'h0;
         s_r.tmo       <= 4'h0;
         s_r.aux_sync  <= 6'h00;
         s_r.aux_st    <= 2'h0;
         s_r.aux_prev  <= 2'h0;
         s_r.chan_prev <= 2'h0;
         s_r.chan_evt  <= 2'h0;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_comb begin
      prdata = 32'h0000_0000;
      if (psel && !pwrite && addr_ok) begin
         unique case (idx)
            `PTU_IDX_CTL_A:  prdata = {28'h000_0000, s_r.ctl_a};
            `PTU_IDX_CTL_B:  prdata = {28'h000_0000, s_r.ctl_b};
            `PTU_IDX_CTL_CD: prdata = {25'h000_0000, s_r.ctl_c, 1'b0, s_r.ctl_d};
            `PTU_IDX_DATA_A: prdata = {24'h00_0000, s_r.hold[0]};
            `PTU_IDX_DATA_B: prdata = {24'h00_0000, s_r.hold[1]};
            `PTU_IDX_DATA_C: prdata = {24'h00_0000, s_r.hold[2]};
            `PTU_IDX_DATA_D: prdata = {24'h00_0000, s_r.hold[3]};
            `PTU_IDX_EDGE:   prdata = {24'h00_0000, s_r.edge_sel};
            default:         prdata = 32'h0000_0000;
         endcase
      end
   end

   assign pready                 = 1'b1;
   assign pslverr                = access & ~mapped;
   assign timer_a_out            = s_r.tout[0];
   assign timer_b_out            = s_r.tout[1];
   assign timer_c_out            = s_r.tout[2];
   assign timer_d_out            = s_r.tout[3];
   assign timer_a_timeout        = s_r.tmo[0];
   assign timer_b_timeout        = s_r.tmo[1];
   assign timer_c_timeout        = s_r.tmo[2];
   assign timer_d_timeout        = s_r.tmo[3];
   assign gp_interrupt_channel_4 = s_r.chan_evt[0];
   assign gp_interrupt_channel_3 = s_r.chan_evt[1];

endmodule

`default_nettype wire

// ### ptu_timer_unit_props.sv
// port assertions of the timer unit
`timescale 1ns/100ps
`default_nettype none
module ptu_timer_unit_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        timer_a_out,
   input wire logic        timer_a_timeout,
   input wire logic        gp_interrupt_channel_4,
   input wire logic        gp_interrupt_channel_3
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_high: assert property (pready) else $error("pready low");
   a_err_align: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr) else $error("no pslverr");
   a_err_phase: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
   a_err_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000) else $error("err data");
   a_rd_upper: assert property (psel && !pwrite |-> prdata[31:8] == 24'h00_0000) else $error("upper bits set");
   a_tmo_pulse: assert property (timer_a_timeout |=> !timer_a_timeout) else $error("long time-out");
   a_out_clear: assert property (psel && penable && pwrite && paddr == 8'h30 && pwdata[4] |=> !timer_a_out)
      else $error("out not cleared");
   a_chan4_pulse: assert property (gp_interrupt_channel_4 |=> !gp_interrupt_channel_4) else $error("ch4 long");
   a_chan3_pulse: assert property (gp_interrupt_channel_3 |=> !gp_interrupt_channel_3) else $error("ch3 long");
   a_reset_low: assert property (disable iff (1'b0) !presetn |-> !timer_a_out) else $error("out in reset");
endmodule
bind ptu_timer_unit ptu_timer_unit_props u_ptu_timer_unit_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .timer_a_out(timer_a_out), .timer_a_timeout(timer_a_timeout),
   .gp_interrupt_channel_4(gp_interrupt_channel_4), .gp_interrupt_channel_3(gp_interrupt_channel_3));
`default_nettype wire

// ### ptu_aux_src.sv
// source of the two auxiliary timer inputs
`timescale 1ns/100ps
`default_nettype none
module ptu_aux_src (
   input  wire logic pclk,
   output logic      aux_a,
   output logic      aux_b
);
   initial begin
      aux_a = 1'b0;
      aux_b = 1'b1;
   end
   // each level held beyond four timer clocks
   task automatic pulse_a(input int n);
      repeat (2 * n) begin
         @(posedge pclk);
         aux_a <= ~aux_a;
         repeat (100) @(posedge pclk);
      end
   endtask
   task automatic drive_b(input logic v, input int hold);
      @(posedge pclk);
      aux_b <= v;
      repeat (hold) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// ### ptu_timer_unit_tb.sv
// testbench of the timer unit
`timescale 1ns/100ps
`default_nettype none
module ptu_timer_unit_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, aux_a, aux_b, err, out_a, tmo_a, gp4, gp3;
   logic        tmo_c, tmo_d;
   int          n_c, n_d;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   int          num_errors, n_tests, cyc, t_prev, t_last, n_tmo, n_gp4, n_gp3, k;
   ptu_timer_unit u_ptu_timer_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_a_aux_input(aux_a), .timer_b_aux_input(aux_b), .timer_a_out(out_a), .timer_b_out(),
      .timer_c_out(), .timer_d_out(), .timer_a_timeout(tmo_a), .timer_b_timeout(), .timer_c_timeout(tmo_c),
      .timer_d_timeout(tmo_d), .gp_interrupt_channel_4(gp4), .gp_interrupt_channel_3(gp3));
   ptu_aux_src u_ptu_aux_src (.pclk(pclk), .aux_a(aux_a), .aux_b(aux_b));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (tmo_a === 1'b1) begin
         t_prev <= t_last;
         t_last <= cyc;
         n_tmo  <= n_tmo + 1;
      end
      if (gp4 === 1'b1) n_gp4 <= n_gp4 + 1;
      if (gp3 === 1'b1) n_gp3 <= n_gp3 + 1;
      if (tmo_c === 1'b1) n_c <= n_c + 1;
      if (tmo_d === 1'b1) n_d <= n_d + 1;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic give_verdict;
      if (num_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_tmo;
      k = n_tmo;
      while (n_tmo == k) @(posedge pclk);
   endtask
   task automatic s_regs;
      apb(1'b1, 8'h30, 32'h0000_0015);
      apb(1'b0, 8'h30, 32'h0000_0000);
      chk("ctl_a", 32'h0000_0005, rd);
      apb(1'b0, 8'h50, 32'h0000_0000);
      chk("unmapped", 32'h0000_0001, {31'h0000_0000, err});
      apb(1'b0, 8'h31, 32'h0000_0000);
      chk("misaligned", 32'h0000_0001, {31'h0000_0000, err});
   endtask
   task automatic s_load;
      apb(1'b1, 8'h30, 32'h0000_0000);
      apb(1'b1, 8'h3C, 32'h0000_0005);
      repeat (200) @(posedge pclk);
      apb(1'b0, 8'h3C, 32'h0000_0000);
      chk("stopped count", 32'h0000_0005, rd);
   endtask
   task automatic s_delay;
      logic o;
      apb(1'b1, 8'h3C, 32'h0000_0002);
      apb(1'b1, 8'h30, 32'h0000_0001);
      wait_tmo;
      wait_tmo;
      chk("delay period", 32'h0000_00A0, 32'(t_last - t_prev));
      apb(1'b1, 8'h3C, 32'h0000_0001);
      o = out_a;
      wait_tmo;
      repeat (4) @(posedge pclk);
      chk("out toggle", {31'h0000_0000, ~o}, {31'h0000_0000, out_a});
      wait_tmo;
      chk("new period", 32'h0000_0050, 32'(t_last - t_prev));
   endtask
   task automatic s_outrst;
      while (out_a !== 1'b1) @(posedge pclk);
      apb(1'b1, 8'h30, 32'h0000_0010);
      @(posedge pclk);
      chk("out reset", 32'h0000_0000, {31'h0000_0000, out_a});
   endtask
   task automatic s_cd;
      int a, b;
      apb(1'b1, 8'h44, 32'h0000_0001);
      apb(1'b1, 8'h48, 32'h0000_0002);
      apb(1'b1, 8'h38, 32'h0000_0011);
      repeat (40) @(posedge pclk);
      a = n_c;
      b = n_d;
      repeat (800) @(posedge pclk);
      chk("c tmo count", 32'h0000_000A, 32'(n_c - a));
      chk("d tmo count", 32'h0000_0005, 32'(n_d - b));
      apb(1'b1, 8'h38, 32'h0000_0000);
   endtask
   task automatic s_event;
      int a, b;
      apb(1'b1, 8'h4C, 32'h0000_0010);
      apb(1'b1, 8'h3C, 32'h0000_0003);
      apb(1'b1, 8'h30, 32'h0000_0008);
      repeat (50) @(posedge pclk);
      a = n_tmo;
      b = n_gp4;
      u_ptu_aux_src.pulse_a(3);
      chk("event tmo", 32'h0000_0001, 32'(n_tmo - a));
      chk("ch4 events", 32'h0000_0003, 32'(n_gp4 - b));
   endtask
   task automatic s_pwidth;
      int a;
      apb(1'b1, 8'h40, 32'h0000_0010);
      apb(1'b1, 8'h34, 32'h0000_0009);
      repeat (400) @(posedge pclk);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("pw halted", 32'h0000_0010, rd);
      a = n_gp3;
      u_ptu_aux_src.drive_b(1'b0, 800);
      u_ptu_aux_src.drive_b(1'b1, 100);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("pw counted", 32'h0000_0001, {31'h0000_0000, rd >= 32'h0000_0005 && rd <= 32'h0000_0007});
      chk("ch3 end", 32'h0000_0001, 32'(n_gp3 - a));
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {num_errors, n_tests, cyc, t_prev, t_last, n_tmo, n_gp4, n_gp3, n_c, n_d} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      s_regs;
      s_load;
      s_delay;
      s_outrst;
      s_cd;
      s_event;
      s_pwidth;
      give_verdict;
   end
   initial begin
      #400_000;
      num_errors++;
      give_verdict;
   end
endmodule
`default_nettype wire
